// >>> logic/jisp_cfg.svh
/*
 * jisp_cfg.svh: constants for the test access port and its host.
 * Assumes inclusion by bare name from the package and the testbench.
 */
`ifndef JISP_CFG_SVH
`define JISP_CFG_SVH

// ****************************************
// register lengths
// ****************************************
`define JISP_IR_LEN       10
`define JISP_ID_LEN       32
`define JISP_BSR_LEN      96

// ****************************************
// instruction codes (10 bits)
// ****************************************
`define JISP_OP_EXTEST    10'h000
`define JISP_OP_SAMPLE    10'h055
`define JISP_OP_IDCODE    10'h059
`define JISP_OP_USERCODE  10'h007
`define JISP_OP_BYPASS    10'h3FF
`define JISP_OP_PGM_DONE  10'h2F3
`define JISP_OP_PGM_ENTER 10'h2CC
`define JISP_OP_PGM_EXIT  10'h201

// ****************************************
// identification word fields, values arbitrary
// ****************************************
`define JISP_ID_VERSION   4'h5
`define JISP_ID_PART      16'hA5C3
`define JISP_ID_MAKER     11'h2B5
`define JISP_USERCODE_RST 32'hFFFFFFFF

// ****************************************
// host timing: tck half period in sys clocks
// ****************************************
`define JISP_TCK_HALF_NS  50
`define JISP_CLK_NS       5
`define JISP_TCK_HALF_CYC ((`JISP_TCK_HALF_NS + `JISP_CLK_NS - 1) / `JISP_CLK_NS)

`endif

// >>> logic/jisp_dev.sv
/*
 * jisp_dev.sv: device end of the test access port with boundary scan
 * and in-system programming. Samples tck on clk_sys and acts on its edges.
 * Assumes tck high and low times of many clk_sys periods.
 */
// Operation
// - programming goes only over four-wire port
// - pins float with pull-up while programming
// - host writes completion flag last
// - outputs off until completion flag set; extest drives pins from scan cells regardless
// - sample/preload captures pins, loads pattern
// - extest drives pins from scan cells
// - bypass is one-bit, one tck delay
// - idcode shifts identification word out
// - usercode shifts 32-bit user word out
// - extra programming instructions over port
// - instruction register ten bits long
// - id and user registers 32 bits
// - scan length set by device density
// - id fields version, part, maker, one
// - id lsb is one, shifted first
// - port disabled frees pins as user io
`timescale 1ns/100ps

module jisp_dev
  import jisp_pkg::*;
#(
  parameter int NPIN    = `JISP_BSR_LEN / 3,
  parameter int BSR_LEN = `JISP_BSR_LEN
) (
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  jisp_link_if.dev             link,
  input  wire logic            port_enable,
  input  wire logic [NPIN-1:0] core_out,
  input  wire logic [NPIN-1:0] core_oe,
  input  wire logic [NPIN-1:0] pin_in,
  output logic      [NPIN-1:0] pin_out,
  output logic      [NPIN-1:0] pin_oe,
  output logic      [NPIN-1:0] pin_pullup,
  output logic      [NPIN-1:0] core_in,
  output logic                 pgm_active,
  output logic                 programming_complete_flag
);

  // ****************************************
  // link synchronisers and edge detect
  // ****************************************
  logic [1:0] tck_s_ff, tms_s_ff, tdi_s_ff;
  logic       tck_d_ff;
  logic       rise, fall;

  // two flops on every pin; tck edges found on the second stage only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tck_s_ff <= 2'h0;
      tms_s_ff <= 2'h3;
      tdi_s_ff <= 2'h3;
      tck_d_ff <= 1'h0;
    end else begin
      tck_s_ff <= {tck_s_ff[0], link.tck};
      tms_s_ff <= {tms_s_ff[0], link.tms};
      tdi_s_ff <= {tdi_s_ff[0], link.tdi};
      tck_d_ff <= tck_s_ff[1];
    end
  end
  assign rise = port_enable & tck_s_ff[1] & ~tck_d_ff;
  assign fall = port_enable & ~tck_s_ff[1] & tck_d_ff;

  // ****************************************
  // tap controller
  // ****************************************
  jisp_tap_t state_ff;

  // standard sequence on rising tck
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !port_enable) begin
      state_ff <= JISP_RESET;
    end else if (rise) begin
      state_ff <= jisp_tap_next(state_ff, tms_s_ff[1]);
    end
  end

  // ****************************************
  // instruction register
  // ****************************************
  logic [`JISP_IR_LEN-1:0] ir_sh_ff, ir_ff;

  // ten-bit shift then update
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state_ff == JISP_RESET) begin
      ir_sh_ff <= '0;
      ir_ff    <= `JISP_OP_IDCODE;
    end else if (rise) begin
      unique case (state_ff)
        JISP_CAP_IR:   ir_sh_ff <= `JISP_IR_LEN'(1);
        JISP_SHIFT_IR: ir_sh_ff <= {tdi_s_ff[1], ir_sh_ff[`JISP_IR_LEN-1:1]};
        JISP_UPD_IR:   ir_ff    <= ir_sh_ff;
        default:       ir_sh_ff <= ir_sh_ff;
      endcase
    end
  end

  logic sel_ext, sel_smp, sel_id, sel_uc, sel_bsr, sel_byp;
  assign sel_ext = (ir_ff == `JISP_OP_EXTEST);
  assign sel_smp = (ir_ff == `JISP_OP_SAMPLE);
  assign sel_id  = (ir_ff == `JISP_OP_IDCODE);
  assign sel_uc  = (ir_ff == `JISP_OP_USERCODE);
  assign sel_bsr = sel_ext | sel_smp;
  // unknown codes fall to bypass, as the standard asks
  assign sel_byp = ~(sel_bsr | sel_id | sel_uc);

  // ****************************************
  // data registers
  // ****************************************
  localparam logic [31:0] ID_WORD = {`JISP_ID_VERSION, `JISP_ID_PART, `JISP_ID_MAKER, 1'b1};
  logic [31:0]        dr32_ff;
  logic               byp_ff;
  logic [BSR_LEN-1:0] bsr_ff, bsr_upd_ff;
  logic               pgm_ff, done_ff;
  logic [31:0]        ucode_ff;
  logic               shift_dr, cap_dr, upd_dr;
  assign shift_dr = rise & (state_ff == JISP_SHIFT_DR);
  assign cap_dr   = rise & (state_ff == JISP_CAP_DR);
  assign upd_dr   = rise & (state_ff == JISP_UPD_DR);

  // id word: lsb one leads out user word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dr32_ff <= 32'h0;
    end else if (cap_dr) begin
      dr32_ff <= sel_uc ? ucode_ff : ID_WORD;
    end else if (shift_dr) begin
      dr32_ff <= {tdi_s_ff[1], dr32_ff[31:1]};
    end
  end

  // single-bit bypass, captures zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      byp_ff <= 1'h0;
    end else if (cap_dr) begin
      byp_ff <= 1'h0;
    end else if (shift_dr) begin
      byp_ff <= tdi_s_ff[1];
    end
  end

  // per-pin cells: input, output, enable; length by density
  logic [BSR_LEN-1:0] cap_vec;
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_cell
      assign cap_vec[3*g]   = pin_in[g];
      assign cap_vec[3*g+1] = core_out[g];
      assign cap_vec[3*g+2] = core_oe[g];
    end
  endgenerate

  // capture pins then load pattern
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bsr_ff     <= '0;
      bsr_upd_ff <= '0;
    end else if (sel_bsr && cap_dr) begin
      bsr_ff <= cap_vec;
    end else if (sel_bsr && shift_dr) begin
      bsr_ff <= {tdi_s_ff[1], bsr_ff[BSR_LEN-1:1]};
    end else if (sel_bsr && upd_dr) begin
      bsr_upd_ff <= bsr_ff;
    end
  end

  // ****************************************
  // programming instructions
  // ****************************************
  // enter/exit/flag write over the port; enter or a flag write of zero erases the flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pgm_ff   <= 1'h0;
      done_ff  <= 1'h0;
      ucode_ff <= `JISP_USERCODE_RST;
    end else if (rise && state_ff == JISP_UPD_IR) begin
      if (ir_sh_ff == `JISP_OP_PGM_ENTER) begin
        pgm_ff  <= 1'h1;
        done_ff <= 1'h0;
      end else if (ir_sh_ff == `JISP_OP_PGM_EXIT) begin
        pgm_ff <= 1'h0;
      end
    end else if (pgm_ff && upd_dr && ir_ff == `JISP_OP_PGM_DONE) begin
      done_ff <= dr32_ff[0]; // host sends this last
    end else if (pgm_ff && upd_dr && sel_uc) begin
      ucode_ff <= dr32_ff;
    end
  end
  // usercode is written only while programming; it is read in either mode
  assign pgm_active                = pgm_ff;
  assign programming_complete_flag = done_ff;

  // ****************************************
  // pins
  // ****************************************
  // float with pull-up in programming; outside extest no drive until flag set
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_comb begin
        pin_out[g]    = (sel_ext & ~pgm_ff) ? bsr_upd_ff[3*g+1] : core_out[g];
        pin_oe[g]     = pgm_ff ? 1'b0 :
                        sel_ext ? bsr_upd_ff[3*g+2] : (core_oe[g] & done_ff);
        pin_pullup[g] = pgm_ff;
        core_in[g]    = pin_in[g]; // sampling never disturbs the core
      end
    end
  endgenerate

  // ****************************************
  // tdo on falling tck
  // ****************************************
  logic tdo_ff, tdo_oe_ff, sel_out;
  always_comb begin
    if (state_ff == JISP_SHIFT_IR) begin
      sel_out = ir_sh_ff[0];
    end else if (sel_byp) begin
      sel_out = byp_ff;
    end else if (sel_bsr) begin
      sel_out = bsr_ff[0];
    end else begin
      sel_out = dr32_ff[0];
    end
  end

  // port off releases tdo as user io update on falling edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !port_enable) begin
      tdo_ff    <= 1'h0;
      tdo_oe_ff <= 1'h0;
    end else if (fall) begin
      tdo_ff    <= sel_out;
      tdo_oe_ff <= (state_ff == JISP_SHIFT_IR) || (state_ff == JISP_SHIFT_DR);
    end
  end
  assign link.tdo    = tdo_ff;
  assign link.tdo_oe = tdo_oe_ff;

endmodule

// >>> logic/jisp_host.sv
/*
 * jisp_host.sv: host end; turns scan commands into tck/tms/tdi.
 * Assumes the device samples tck with a much faster clock.
 */
`timescale 1ns/100ps

module jisp_host
  import jisp_pkg::*;
#(
  parameter int HALF = `JISP_TCK_HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  jisp_link_if.host        link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  jisp_cmd_t        cmd_kind,
  input  wire logic [5:0]  cmd_len,
  input  wire logic [31:0] cmd_data,
  output logic             rsp_valid,
  output logic [31:0]      rsp_data
);

  // ****************************************
  // tck divider and sequencing
  // ****************************************
  typedef enum logic [1:0] {
    JISP_H_IDLE = 2'h0,
    JISP_H_RUN  = 2'h1
  } jisp_hst_t;

  jisp_hst_t   hst_ff;
  logic [7:0]  div_ff;
  logic        tck_ff, tms_ff, tdi_ff;
  logic [3:0]  seq_ff;
  logic [5:0]  cnt_ff;
  logic [31:0] sh_ff;
  jisp_tap_t   tap_ff;
  logic        rsp_ff;
  logic [1:0]  tdo_s_ff;
  logic        half_end;

  assign half_end  = (div_ff == 8'(HALF - 1));
  assign cmd_ready = (hst_ff == JISP_H_IDLE);

  // tdo is from another domain: two flops before use
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tdo_s_ff <= 2'h0;
    end else begin
      tdo_s_ff <= {tdo_s_ff[0], link.tdo};
    end
  end

  // next tms: path idle->shift, shift len bits, exit->update->idle
  function automatic logic next_tms(input jisp_tap_t t, input jisp_cmd_t k, input logic [5:0] c);
    logic m;
    m = 1'b0;
    unique case (t)
      JISP_IDLE:     m = 1'b1;
      JISP_SEL_DR:   m = (k == JISP_CMD_IR);
      JISP_SHIFT_DR,
      JISP_SHIFT_IR: m = (c == 6'h1);
      JISP_EXIT1_DR,
      JISP_EXIT1_IR: m = 1'b1;
      default:       m = 1'b0;
    endcase
    return m;
  endfunction

  // all programming runs through this port
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hst_ff <= JISP_H_IDLE;
      div_ff <= 8'h0;
      tck_ff <= 1'h0;
      tms_ff <= 1'h1;
      tdi_ff <= 1'h1;
      seq_ff <= 4'h0;
      cnt_ff <= 6'h0;
      sh_ff  <= 32'h0;
      tap_ff <= JISP_RESET;
      rsp_ff <= 1'h0;
    end else begin
      rsp_ff <= 1'h0;
      unique case (hst_ff)
        JISP_H_IDLE: begin
          div_ff <= 8'h0;
          if (cmd_valid) begin
            hst_ff <= JISP_H_RUN;
            cnt_ff <= cmd_len; // ir loads use length ten
            sh_ff  <= cmd_data;
            seq_ff <= (cmd_kind == JISP_CMD_RST) ? 4'h6 : 4'h0;
            tms_ff <= (cmd_kind == JISP_CMD_RST) ? 1'b1
                      : ((tap_ff == JISP_RESET) ? 1'b0 : 1'b1);
          end
        end
        JISP_H_RUN: begin
          div_ff <= half_end ? 8'h0 : 8'(div_ff + 8'h1);
          if (half_end) begin
            tck_ff <= ~tck_ff;
            if (!tck_ff) begin
              // rising edge: tap advances, shift consumes one bit
              tap_ff <= jisp_tap_next(tap_ff, tms_ff);
              if (tap_ff == JISP_SHIFT_DR || tap_ff == JISP_SHIFT_IR) begin
                sh_ff  <= {tdo_s_ff[1], sh_ff[31:1]};
                cnt_ff <= 6'(cnt_ff - 6'h1);
              end
              if (seq_ff != 4'h0) begin
                seq_ff <= 4'(seq_ff - 4'h1);
              end
            end else begin
              // falling edge: present tms/tdi for next rise
              tdi_ff <= sh_ff[0];
              if (seq_ff != 4'h0) begin
                tms_ff <= (seq_ff != 4'h1);
              end else if (tap_ff == JISP_IDLE && cnt_ff == 6'h0) begin
                hst_ff <= JISP_H_IDLE;
                rsp_ff <= 1'h1;
                tms_ff <= 1'h0;
              end else if (tap_ff == JISP_RESET) begin
                tms_ff <= 1'h0;
              end else begin
                tms_ff <= next_tms(tap_ff, cmd_kind, cnt_ff);
              end
            end
          end
        end
        default: hst_ff <= JISP_H_IDLE;
      endcase
    end
  end

  assign link.tck  = tck_ff;
  assign link.tms  = tms_ff;
  assign link.tdi  = tdi_ff;
  assign rsp_valid = rsp_ff;
  // captured bits sit in the top of the word for short scans
  assign rsp_data  = sh_ff;

endmodule

// >>> logic/jisp_link_if.sv
/*
 * jisp_link_if.sv: the four-wire test port between host and device.
 * Assumes the bench drives nothing; the host makes tck, tms and tdi.
 */
`timescale 1ns/100ps

interface jisp_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;

  // host drives clock, mode and data in; device answers on tdo
  modport host (output tck, output tms, output tdi, input tdo, input tdo_oe);
  modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe);
endinterface

// >>> logic/jisp_pkg.sv
/*
 * jisp_pkg.sv: types shared by both ends of the test port.
 * Assumes jisp_cfg.svh is on the include path.
 */
`include "jisp_cfg.svh"

package jisp_pkg;

  // tap controller states
  typedef enum logic [3:0] {
    JISP_RESET      = 4'h0,
    JISP_IDLE       = 4'h1,
    JISP_SEL_DR     = 4'h2,
    JISP_CAP_DR     = 4'h3,
    JISP_SHIFT_DR   = 4'h4,
    JISP_EXIT1_DR   = 4'h5,
    JISP_PAUSE_DR   = 4'h6,
    JISP_EXIT2_DR   = 4'h7,
    JISP_UPD_DR     = 4'h8,
    JISP_SEL_IR     = 4'h9,
    JISP_CAP_IR     = 4'hA,
    JISP_SHIFT_IR   = 4'hB,
    JISP_EXIT1_IR   = 4'hC,
    JISP_PAUSE_IR   = 4'hD,
    JISP_EXIT2_IR   = 4'hE,
    JISP_UPD_IR     = 4'hF
  } jisp_tap_t;

  // host command kinds
  typedef enum logic [1:0] {
    JISP_CMD_IR  = 2'h0,
    JISP_CMD_DR  = 2'h1,
    JISP_CMD_RST = 2'h2
  } jisp_cmd_t;

  // tap next-state function, shared by both ends
  function automatic jisp_tap_t jisp_tap_next(input jisp_tap_t s, input logic m);
    jisp_tap_t n;
    n = s;
    unique case (s)
      JISP_RESET:    n = m ? JISP_RESET   : JISP_IDLE;
      JISP_IDLE:     n = m ? JISP_SEL_DR  : JISP_IDLE;
      JISP_SEL_DR:   n = m ? JISP_SEL_IR  : JISP_CAP_DR;
      JISP_CAP_DR:   n = m ? JISP_EXIT1_DR : JISP_SHIFT_DR;
      JISP_SHIFT_DR: n = m ? JISP_EXIT1_DR : JISP_SHIFT_DR;
      JISP_EXIT1_DR: n = m ? JISP_UPD_DR  : JISP_PAUSE_DR;
      JISP_PAUSE_DR: n = m ? JISP_EXIT2_DR : JISP_PAUSE_DR;
      JISP_EXIT2_DR: n = m ? JISP_UPD_DR  : JISP_SHIFT_DR;
      JISP_UPD_DR:   n = m ? JISP_SEL_DR  : JISP_IDLE;
      JISP_SEL_IR:   n = m ? JISP_RESET   : JISP_CAP_IR;
      JISP_CAP_IR:   n = m ? JISP_EXIT1_IR : JISP_SHIFT_IR;
      JISP_SHIFT_IR: n = m ? JISP_EXIT1_IR : JISP_SHIFT_IR;
      JISP_EXIT1_IR: n = m ? JISP_UPD_IR  : JISP_PAUSE_IR;
      JISP_PAUSE_IR: n = m ? JISP_EXIT2_IR : JISP_PAUSE_IR;
      JISP_EXIT2_IR: n = m ? JISP_UPD_IR  : JISP_SHIFT_IR;
      JISP_UPD_IR:   n = m ? JISP_SEL_DR  : JISP_IDLE;
    endcase
    return n;
  endfunction

endpackage

// >>> verification/jisp_link_sva.sv
/*
 * jisp_link_sva.sv: assertions on the four-wire test port.
 * Assumes the host tck half period is HALF clk_sys cycles.
 */
`timescale 1ns/100ps

module jisp_link_sva #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ****************************************
  // helper counters
  // ****************************************
  int hi_cnt;
  int lo_cnt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // consecutive high and low samples of tck; preset so the first rise passes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hi_cnt <= 0;
      lo_cnt <= HALF;
    end else begin
      hi_cnt <= tck ? hi_cnt + 1 : 0;
      lo_cnt <= tck ? 0 : lo_cnt + 1;
    end
  end

  // ****************************************
  // port timing
  // ****************************************
  reset_vals_a: assert property ($fell(sys_rst) |-> !tck && tms && tdi)
    else $error("port not idle after reset");
  tck_high_a: assert property ($fell(tck) |-> hi_cnt == HALF)
    else $error("tck high time wrong");
  tck_low_a: assert property ($rose(tck) |-> lo_cnt >= HALF)
    else $error("tck low time short");
  tms_hold_a: assert property (tck && $past(tck) |-> $stable(tms))
    else $error("tms moved while tck high");
  tdi_hold_a: assert property (tck && $past(tck) |-> $stable(tdi))
    else $error("tdi moved while tck high");
  tdo_fall_a: assert property ($changed(tdo) && tdo_oe |-> !tck && lo_cnt < HALF)
    else $error("tdo not updated after tck fall");
  tdo_steady_a: assert property ($rose(tck) |-> $stable(tdo) [*3])
    else $error("tdo moved around tck rise");
  tdo_oe_edge_a: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo enable moved while tck high");
endmodule

// >>> verification/testbench.sv
/*
 * testbench.sv: host and device joined by the link; commands go in at the
 * host, scan answers and device pins are compared. Assumes the logic/ files.
 */
`timescale 1ns/100ps
`include "jisp_cfg.svh"

module testbench
  import jisp_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  // a host tck rise must see tdo after the device's sync, edge detect and
  // update plus the host's own two sync flops: about six clocks, so four is short
  localparam int HALF = `JISP_TCK_HALF_CYC;
  logic        clk_sys, sys_rst, cmd_valid, cmd_ready, rsp_valid;
  logic        port_enable, pgm_active, programming_complete_flag;
  jisp_cmd_t   cmd_kind;
  logic [5:0]  cmd_len;
  logic [31:0] cmd_data, rsp_data;
  logic [31:0] core_out, core_oe, pin_in, pin_out, pin_oe, pin_pullup, core_in;
  int          err_count, samples_checked;

  jisp_link_if link ();

  jisp_host #(.HALF(HALF)) i_jisp_host (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_len(cmd_len),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  jisp_dev i_jisp_dev (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .port_enable(port_enable),
    .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .core_in(core_in),
    .pgm_active(pgm_active), .programming_complete_flag(programming_complete_flag));

  jisp_link_sva #(.HALF(HALF)) u_sva (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .tck(link.tck), .tms(link.tms),
    .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));

  // ****************************************
  // tasks
  // ****************************************
  // one command; held until taken, then wait bounded for the answer
  task automatic run(input jisp_cmd_t k, input logic [5:0] n, input logic [31:0] d);
    int w;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_len   <= n;
    cmd_data  <= d;
    w = 0;
    do @(negedge clk_sys); while (cmd_ready !== 1'b1 && ++w < 200);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    w = 0;
    do @(negedge clk_sys); while (rsp_valid !== 1'b1 && ++w < 5000);
    if (w >= 5000) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // clock, reset, watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // a hang in the handshake ends here; the tests need about 45 us
  initial begin
    #200000;
    err_count++;
    conclude();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = JISP_CMD_RST;
    cmd_len = 6'h00;
    cmd_data = 32'h0;
    port_enable = 1'b1;
    core_out = 32'hA5A50F0F;
    core_oe = 32'hFFFF0000;
    pin_in = 32'h12345678;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    // flag clear: drivers stay off although the core enables them
    chk(pin_oe, 32'h0);
    chk({31'h0, programming_complete_flag}, 32'h0);
    // tap reset leaves the identification word selected, lsb first
    run(JISP_CMD_RST, 6'h00, 32'h0);
    run(JISP_CMD_DR, 6'd32, 32'h0);
    chk(rsp_data, {`JISP_ID_VERSION, `JISP_ID_PART, `JISP_ID_MAKER, 1'b1});
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_IDCODE});
    run(JISP_CMD_DR, 6'd32, 32'hFFFFFFFF);
    chk(rsp_data, {`JISP_ID_VERSION, `JISP_ID_PART, `JISP_ID_MAKER, 1'b1});
    // bypass: a zero from capture, then tdi one tck late
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_BYPASS});
    run(JISP_CMD_DR, 6'd8, 32'hA5);
    chk({24'h0, rsp_data[31:24]}, 32'h4A);
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_USERCODE});
    run(JISP_CMD_DR, 6'd32, 32'h0);
    chk(rsp_data, `JISP_USERCODE_RST);
    // programming: pins float pulled up, user word written, flag last
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_PGM_ENTER});
    chk({31'h0, pgm_active}, 32'h1);
    chk(pin_oe, 32'h0);
    chk(pin_pullup, 32'hFFFFFFFF);
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_USERCODE});
    run(JISP_CMD_DR, 6'd32, 32'h5A3C96E1);
    chk(pin_oe, 32'h0);
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_PGM_DONE});
    run(JISP_CMD_DR, 6'd32, 32'h1);
    chk({31'h0, programming_complete_flag}, 32'h1);
    chk(pin_oe, 32'h0);
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_PGM_EXIT});
    chk({31'h0, pgm_active}, 32'h0);
    chk(pin_oe, core_oe);
    chk(pin_out, core_out);
    // sample leaves the pins with the core
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_SAMPLE});
    run(JISP_CMD_DR, 6'd32, 32'hC3C3C3C3);
    chk(pin_out, core_out);
    chk(pin_oe, core_oe);
    chk(core_in, pin_in);
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_USERCODE});
    run(JISP_CMD_DR, 6'd32, 32'h0);
    chk(rsp_data, 32'h5A3C96E1);
    // extest sets pins 31 and 30 from the preloaded top cells; only 31 is driven
    run(JISP_CMD_IR, 6'd10, {22'h0, `JISP_OP_EXTEST});
    chk({28'h0, pin_oe[31:30], pin_out[31:30]}, 32'hA);
    // port disabled: device lets go of tdo
    @(posedge clk_sys);
    port_enable <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk({31'h0, link.tdo_oe}, 32'h0);
    conclude();
  end
endmodule
